// ===== logic/pmic_top.sv
// How it works
// - Plain sleep from active enters standby, watch or sleep by standby and low-speed bits.
// - Plain sleep from subactive enters watch or subsleep.
// - Direct transfer from high-speed active to medium-speed active on matching bits.
// - Direct transfer from medium-speed active to high-speed active on matching bits.
// - Direct transfer from either active speed to subactive on matching bits.
// - Direct transfer from subactive to high-speed active on matching bits.
// - Direct transfer from subactive to medium-speed active on matching bits.
// - Medium-speed bit picks active speed: 0 high, 1 medium.
// - Subclock divider field: 00 divides watch clock by 8, 01 by 4, 1x by 2.
// - Noise filter sampling: 0 oscillator divided by 16, 1 divided by 4.
// - Timer A flag sets when its counter wraps from maximum to zero.
// - Line flag sets on the chosen edge of a pin in interrupt mode.
// - Flags clear only by writing 0 while set; writing 1 does nothing.
// - Serial-1 flag sets when a serial unit one transfer completes.
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
module pmic_top
  import pmic_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic                sleep_exec,
  input  wire logic                timer_clock_source_bit,
  input  wire logic [7:0]          timer_a_count,
  input  wire logic                serial1_done,
  input  wire logic                wakeup_req,
  input  wire logic                watch_tick,
  input  wire logic [LINE_CNT-1:0] irq_line,
  input  pmic_line_cfg_s           line_cfg,
  output pmic_mode_e               power_mode,
  output logic [2:0]               standby_wait_select,
  output logic                     subclock_en,
  output logic                     noise_sample_en,
  output logic [7:0]               cpu_irq_req
);

  // ------------------------------------------------------------
  // Registers and decoded fields
  // ------------------------------------------------------------
  logic [7:0]          sys_ctl1_r;
  logic [7:0]          sys_ctl2_r;
  logic [7:0]          irq_en1_r;
  logic [7:0]          irq_req1_r;
  logic [7:0]          ta_prev_r;
  logic [LINE_CNT-1:0] line_evt;
  logic [7:0]          irq_set;
  logic [7:0]          irq_clr;
  logic                ta_wrap;
  logic                wake;
  pmic_mode_e          mode_r;
  pmic_mode_e          mode_nxt;
  pmic_mode_e          active_mode;

  logic software_standby_select;
  logic low_speed_select;
  logic direct_transfer_select;
  logic medium_speed_select;
  logic noise_sample_rate_select;
  logic [1:0] subclock_divider_select;

  assign software_standby_select  = sys_ctl1_r[SC1_SOFTWARE_STANDBY_SELECT];
  assign low_speed_select         = sys_ctl1_r[SC1_LOW_SPEED_SELECT];
  assign standby_wait_select      = sys_ctl1_r[SC1_STS_LSB +: 3];
  assign direct_transfer_select   = sys_ctl2_r[SC2_DIRECT_TRANSFER_SELECT];
  assign medium_speed_select      = sys_ctl2_r[SC2_MEDIUM_SPEED_SELECT];
  assign noise_sample_rate_select = sys_ctl2_r[SC2_NOISE_SAMPLE_RATE_SELECT];
  assign subclock_divider_select  = sys_ctl2_r[SC2_SA_LSB +: 2];
  assign power_mode               = mode_r;

  // ------------------------------------------------------------
  // AXI4-Lite slave
  // ------------------------------------------------------------
  logic              aw_hold_r;
  logic              w_hold_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [7:0]        w_byte_r;
  logic              w_lane_r;
  logic              wr_fire;
  logic              wr_lane0;
  pmic_reg_e         wr_sel;

  // Address and data may arrive in either order; each is held until both are in
  assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire       = aw_hold_r && w_hold_r && !s_axi_bvalid;
  assign wr_sel        = pmic_decode(aw_addr_r);
  assign wr_lane0      = wr_fire && w_lane_r;

  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_hold_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end
    else if (wr_fire)
      aw_hold_r <= 1'b0;

  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      w_hold_r <= 1'b0;
      w_byte_r <= 8'h00;
      w_lane_r <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_hold_r <= 1'b1;
      w_byte_r <= s_axi_wdata[7:0];
      w_lane_r <= s_axi_wstrb[0];
    end
    else if (wr_fire)
      w_hold_r <= 1'b0;

  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_sel == PMIC_REG_NONE) ? RESP_DECERR : RESP_OKAY;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;

  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      unique case (pmic_decode(s_axi_araddr))
        PMIC_REG_SC1: s_axi_rdata <= {24'h00_0000, sys_ctl1_r};
        PMIC_REG_SC2: s_axi_rdata <= {24'h00_0000, sys_ctl2_r};
        PMIC_REG_IEN: s_axi_rdata <= {24'h00_0000, irq_en1_r};
        PMIC_REG_IRR: s_axi_rdata <= {24'h00_0000, irq_req1_r};
        PMIC_REG_NONE:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_DECERR;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  // Reserved bits keep their reset ones through the write masks
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      sys_ctl1_r <= SC1_RESET;
      sys_ctl2_r <= SC2_RESET;
      irq_en1_r  <= IEN_RESET;
    end
    else if (wr_lane0)
    begin
      if (wr_sel == PMIC_REG_SC1)
        sys_ctl1_r <= pmic_apply(sys_ctl1_r, w_byte_r, SC1_WMASK);
      if (wr_sel == PMIC_REG_SC2)
        sys_ctl2_r <= pmic_apply(sys_ctl2_r, w_byte_r, SC2_WMASK);
      // Serial-1 and line-2 enables are stored as written; small parts expect 0
      if (wr_sel == PMIC_REG_IEN)
        irq_en1_r <= pmic_apply(irq_en1_r, w_byte_r, IEN_WMASK);
    end

  // ------------------------------------------------------------
  // Request flags
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
      ta_prev_r <= TA_COUNT_MIN;
    else
      ta_prev_r <= timer_a_count;

  assign ta_wrap = (ta_prev_r == TA_COUNT_MAX) && (timer_a_count == TA_COUNT_MIN);

  always_comb
  begin
    irq_set = 8'h00;
    irq_set[IRQ_TA] = ta_wrap;
    irq_set[IRQ_S1] = serial1_done;
    irq_set[LINE_CNT-1:0] = line_evt;
  end

  // Only a written 0 clears, and only a flag that is set
  assign irq_clr = (wr_lane0 && wr_sel == PMIC_REG_IRR) ? (~w_byte_r & IRR_FLAGS) : 8'h00;

  // A new event in the clearing cycle survives: set wins
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
      irq_req1_r <= IRR_RESET;
    else
      irq_req1_r <= (irq_req1_r & ~irq_clr) | (irq_set & IRR_FLAGS);

  // Wakeup pins keep their own flags elsewhere; only the gate lives here
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
      cpu_irq_req <= 8'h00;
    else
    begin
      cpu_irq_req <= irq_req1_r & IRR_FLAGS & irq_en1_r;
      cpu_irq_req[IRQ_WKP] <= wakeup_req && irq_en1_r[IRQ_WKP];
    end

  assign wake = |cpu_irq_req;

  // ------------------------------------------------------------
  // Power mode sequencer
  // ------------------------------------------------------------
  assign active_mode = medium_speed_select ? PMIC_ACT_MED : PMIC_ACT_HIGH;

  always_comb
  begin
    mode_nxt = mode_r;
    unique case (mode_r)
      PMIC_ACT_HIGH, PMIC_ACT_MED:
        if (sleep_exec)
        begin
          if (direct_transfer_select && !software_standby_select && !low_speed_select
              && mode_r == PMIC_ACT_HIGH && medium_speed_select)
            mode_nxt = PMIC_ACT_MED;
          else if (direct_transfer_select && !software_standby_select && !low_speed_select
                   && mode_r == PMIC_ACT_MED && !medium_speed_select)
            mode_nxt = PMIC_ACT_HIGH;
          else if (direct_transfer_select && software_standby_select
                   && timer_clock_source_bit && low_speed_select)
            mode_nxt = PMIC_SUBACTIVE;
          else if (!software_standby_select)
            mode_nxt = PMIC_SLEEP;
          else
            mode_nxt = low_speed_select ? PMIC_WATCH : PMIC_STANDBY;
        end
      PMIC_SUBACTIVE:
        if (sleep_exec)
        begin
          if (direct_transfer_select && software_standby_select
              && timer_clock_source_bit && !low_speed_select)
            mode_nxt = active_mode;
          else
            mode_nxt = software_standby_select ? PMIC_WATCH : PMIC_SUBSLEEP;
        end
      PMIC_SLEEP, PMIC_STANDBY:
        if (wake)
          mode_nxt = active_mode;
      PMIC_SUBSLEEP:
        if (wake)
          mode_nxt = PMIC_SUBACTIVE;
      PMIC_WATCH:
        if (wake)
          mode_nxt = low_speed_select ? PMIC_SUBACTIVE : active_mode;
      default:
        mode_nxt = PMIC_ACT_HIGH;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
      mode_r <= PMIC_ACT_HIGH;
    else
      mode_r <= mode_nxt;

  // ------------------------------------------------------------
  // Clock enables and edge detection
  // ------------------------------------------------------------
  pmic_clk_div u_clk_div (
    .clk             (clk),
    .sys_rst         (sys_rst),
    .watch_tick      (watch_tick),
    .sub_sel         (subclock_divider_select),
    .noise_sel       (noise_sample_rate_select),
    .subclock_en     (subclock_en),
    .noise_sample_en (noise_sample_en)
  );

  pmic_edge_det u_edge_det (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .irq_line (irq_line),
    .line_cfg (line_cfg),
    .line_evt (line_evt)
  );

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_direct_sleep(pmic_mode_e m);
    mode_r == m && sleep_exec && direct_transfer_select;
  endsequence

  sequence s_plain_sleep(pmic_mode_e m);
    mode_r == m && sleep_exec && !direct_transfer_select;
  endsequence

  chk_plain_active_sleep: assert property (
    s_plain_sleep(PMIC_ACT_HIGH) |=> mode_r == (!$past(software_standby_select) ? PMIC_SLEEP
      : ($past(low_speed_select) ? PMIC_WATCH : PMIC_STANDBY)))
    else $error("active sleep entered wrong mode");

  chk_plain_sub_sleep: assert property (
    s_plain_sleep(PMIC_SUBACTIVE) |=> (mode_r == PMIC_WATCH) == $past(software_standby_select))
    else $error("subactive sleep entered wrong mode");

  chk_high_to_medium: assert property (
    s_direct_sleep(PMIC_ACT_HIGH) ##0 (!software_standby_select && medium_speed_select
      && !low_speed_select) |=> mode_r == PMIC_ACT_MED)
    else $error("no direct move to medium speed");

  chk_medium_to_high: assert property (
    s_direct_sleep(PMIC_ACT_MED) ##0 (!software_standby_select && !medium_speed_select
      && !low_speed_select) |=> mode_r == PMIC_ACT_HIGH)
    else $error("no direct move to high speed");

  chk_active_to_sub: assert property (
    (s_direct_sleep(PMIC_ACT_HIGH) or s_direct_sleep(PMIC_ACT_MED)) ##0
      (software_standby_select && timer_clock_source_bit && low_speed_select)
      |=> mode_r == PMIC_SUBACTIVE)
    else $error("no direct move to subactive");

  chk_sub_to_high: assert property (
    s_direct_sleep(PMIC_SUBACTIVE) ##0 (software_standby_select && timer_clock_source_bit
      && !low_speed_select && !medium_speed_select) |=> mode_r == PMIC_ACT_HIGH)
    else $error("no direct move from subactive to high speed");

  chk_sub_to_medium: assert property (
    s_direct_sleep(PMIC_SUBACTIVE) ##0 (software_standby_select && timer_clock_source_bit
      && !low_speed_select && medium_speed_select) |=> mode_r == PMIC_ACT_MED)
    else $error("no direct move from subactive to medium speed");

  chk_wake_speed: assert property (
    (mode_r == PMIC_SLEEP && wake) |=> mode_r == ($past(medium_speed_select)
      ? PMIC_ACT_MED : PMIC_ACT_HIGH))
    else $error("wake entered wrong active speed");

  chk_timer_wrap_flag: assert property (
    ta_wrap |=> irq_req1_r[IRQ_TA] ##1 cpu_irq_req[IRQ_TA] == $past(irq_en1_r[IRQ_TA]))
    else $error("timer A wrap lost");

  chk_line_edge_flag: assert property (
    (|line_evt) |=> (irq_req1_r[LINE_CNT-1:0] & $past(line_evt)) == $past(line_evt))
    else $error("line edge did not set flag");

  chk_serial_done_flag: assert property (
    serial1_done |=> irq_req1_r[IRQ_S1])
    else $error("serial completion did not set flag");

  chk_flag_clear_zero: assert property (
    (wr_lane0 && wr_sel == PMIC_REG_IRR && !w_byte_r[IRQ_TA] && !ta_wrap)
      |=> !irq_req1_r[IRQ_TA])
    else $error("writing 0 did not clear flag");

  chk_flag_write_one: assert property (
    (!irq_req1_r[IRQ_S1] && !serial1_done) |=> !irq_req1_r[IRQ_S1])
    else $error("flag set without an event");

  chk_irq_gating: assert property (
    (irq_req1_r[IRQ_S1] && !irq_en1_r[IRQ_S1]) |=> !cpu_irq_req[IRQ_S1])
    else $error("disabled source reached the CPU");

endmodule

// ===== logic/pmic_pkg.sv
package pmic_pkg;

  // ------------------------------------------------------------
  // Register map: printed offsets are indices, byte address = 4 x index
  // ------------------------------------------------------------
  localparam int          ADDR_W       = 12;
  localparam logic [9:0]  IDX_SYS_CTL1 = 10'h0f0;
  localparam logic [9:0]  IDX_SYS_CTL2 = 10'h0f1;
  localparam logic [9:0]  IDX_IRQ_EN1  = 10'h0f3;
  localparam logic [9:0]  IDX_IRQ_REQ1 = 10'h0f6;

  // ------------------------------------------------------------
  // Reset values and writable masks
  // ------------------------------------------------------------
  localparam logic [7:0] SC1_RESET = 8'h07;
  localparam logic [7:0] SC1_WMASK = 8'hf8;
  localparam logic [7:0] SC2_RESET = 8'he0;
  localparam logic [7:0] SC2_WMASK = 8'h1f;
  localparam logic [7:0] IEN_RESET = 8'h00;
  localparam logic [7:0] IEN_WMASK = 8'hff;
  localparam logic [7:0] IRR_RESET = 8'h20;
  localparam logic [7:0] IRR_FLAGS = 8'hdf;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int SC1_SOFTWARE_STANDBY_SELECT    = 7;
  localparam int SC1_STS_LSB = 4;
  localparam int SC1_LOW_SPEED_SELECT    = 3;
  localparam int SC2_NOISE_SAMPLE_RATE_SELECT   = 4;
  localparam int SC2_DIRECT_TRANSFER_SELECT    = 3;
  localparam int SC2_MEDIUM_SPEED_SELECT    = 2;
  localparam int SC2_SA_LSB  = 0;
  localparam int IRQ_TA      = 7;
  localparam int IRQ_S1      = 6;
  localparam int IRQ_WKP     = 5;
  localparam int LINE_CNT    = 5;

  // ------------------------------------------------------------
  // Counts and codes
  // ------------------------------------------------------------
  localparam logic [7:0] TA_COUNT_MAX = 8'hff;
  localparam logic [7:0] TA_COUNT_MIN = 8'h00;
  localparam logic [3:0] NOISE_LAST_SLOW = 4'hf;
  localparam logic [3:0] NOISE_LAST_FAST = 4'h3;
  localparam logic [2:0] SUB_LAST_DIV8 = 3'h7;
  localparam logic [2:0] SUB_LAST_DIV4 = 3'h3;
  localparam logic [2:0] SUB_LAST_DIV2 = 3'h1;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [2:0] {
    PMIC_ACT_HIGH, PMIC_ACT_MED, PMIC_SUBACTIVE, PMIC_SLEEP,
    PMIC_SUBSLEEP, PMIC_WATCH, PMIC_STANDBY
  } pmic_mode_e;

  typedef enum logic [2:0] {
    PMIC_REG_SC1, PMIC_REG_SC2, PMIC_REG_IEN, PMIC_REG_IRR, PMIC_REG_NONE
  } pmic_reg_e;

  typedef struct packed {
    logic [LINE_CNT-1:0] pin_irq_mode;
    logic [LINE_CNT-1:0] edge_rising;
  } pmic_line_cfg_s;

  function automatic pmic_reg_e pmic_decode(input logic [ADDR_W-1:0] addr);
    if (addr[1:0] != 2'h0)
      return PMIC_REG_NONE;
    unique case (addr[ADDR_W-1:2])
      IDX_SYS_CTL1: return PMIC_REG_SC1;
      IDX_SYS_CTL2: return PMIC_REG_SC2;
      IDX_IRQ_EN1:  return PMIC_REG_IEN;
      IDX_IRQ_REQ1: return PMIC_REG_IRR;
      default:      return PMIC_REG_NONE;
    endcase
  endfunction

  function automatic logic [7:0] pmic_apply(input logic [7:0] cur, input logic [7:0] wd,
                                            input logic [7:0] mask);
    return (cur & ~mask) | (wd & mask);
  endfunction

  function automatic logic [3:0] pmic_noise_last(input logic sel);
    return sel ? NOISE_LAST_FAST : NOISE_LAST_SLOW;
  endfunction

  function automatic logic [2:0] pmic_sub_last(input logic [1:0] sel);
    if (sel[1])
      return SUB_LAST_DIV2;
    return sel[0] ? SUB_LAST_DIV4 : SUB_LAST_DIV8;
  endfunction

endpackage

// ===== logic/pmic_clk_div.sv
`timescale 1ns/1ps
module pmic_clk_div
  import pmic_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       watch_tick,
  input  wire logic [1:0] sub_sel,
  input  wire logic       noise_sel,
  output logic            subclock_en,
  output logic            noise_sample_en
);

  logic [3:0] noise_cnt_r;
  logic [2:0] sub_cnt_r;
  logic [4:0] noise_gap_r;
  logic [3:0] sub_gap_r;
  logic       nsel_q_r;
  logic [1:0] ssel_q_r;
  logic       nmix_r;
  logic       smix_r;

  // Compare with >= so a ratio change mid-count never runs past the end
  assign noise_sample_en = (noise_cnt_r >= pmic_noise_last(noise_sel));
  assign subclock_en     = watch_tick && (sub_cnt_r >= pmic_sub_last(sub_sel));

  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
      noise_cnt_r <= 4'h0;
    else if (noise_sample_en)
      noise_cnt_r <= 4'h0;
    else
      noise_cnt_r <= noise_cnt_r + 4'h1;

  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
      sub_cnt_r <= 3'h0;
    else if (subclock_en)
      sub_cnt_r <= 3'h0;
    else if (watch_tick)
      sub_cnt_r <= sub_cnt_r + 3'h1;

  // Checking helpers: spacing of pulses and whether the ratio moved in between
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      noise_gap_r <= 5'h01;
      sub_gap_r   <= 4'h1;
      nsel_q_r    <= 1'b0;
      ssel_q_r    <= 2'h0;
      nmix_r      <= 1'b0;
      smix_r      <= 1'b0;
    end
    else
    begin
      nsel_q_r    <= noise_sel;
      ssel_q_r    <= sub_sel;
      noise_gap_r <= noise_sample_en ? 5'h01 : noise_gap_r + 5'h01;
      nmix_r      <= noise_sample_en ? 1'b0 : (nmix_r | (noise_sel != nsel_q_r));
      smix_r      <= subclock_en ? 1'b0 : (smix_r | (sub_sel != ssel_q_r));
      if (watch_tick)
        sub_gap_r <= subclock_en ? 4'h1 : sub_gap_r + 4'h1;
    end

  chk_noise_rate_period: assert property (@(posedge clk) disable iff (sys_rst)
    (noise_sample_en && !nmix_r && (noise_sel == nsel_q_r))
      |-> (noise_gap_r == {1'b0, pmic_noise_last(noise_sel)} + 5'h01))
    else $error("noise sample period wrong");

  chk_subclock_ratio: assert property (@(posedge clk) disable iff (sys_rst)
    (subclock_en && !smix_r && (sub_sel == ssel_q_r))
      |-> (sub_gap_r == {1'b0, pmic_sub_last(sub_sel)} + 4'h1))
    else $error("subclock divide ratio wrong");

endmodule

// ===== logic/pmic_edge_det.sv
`timescale 1ns/1ps
module pmic_edge_det
  import pmic_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic [LINE_CNT-1:0] irq_line,
  input  pmic_line_cfg_s           line_cfg,
  output logic      [LINE_CNT-1:0] line_evt
);

  logic [LINE_CNT-1:0] prev_r;
  logic [LINE_CNT-1:0] rise;
  logic [LINE_CNT-1:0] fall;
  logic                primed_r;

  assign rise = irq_line & ~prev_r;
  assign fall = ~irq_line & prev_r;

  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
      prev_r <= '0;
    else
      prev_r <= irq_line;

  // The first sample after reset only primes the history, so an idle-high pin is no edge
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
      primed_r <= 1'b0;
    else
      primed_r <= 1'b1;

  // Pins not in interrupt mode never raise a request
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
      line_evt <= '0;
    else if (!primed_r)
      line_evt <= '0;
    else
      line_evt <= line_cfg.pin_irq_mode & ((line_cfg.edge_rising & rise)
                                         | (~line_cfg.edge_rising & fall));

endmodule

// ===== test/pmic_top_bench.sv
`timescale 1ns/1ps
module pmic_top_bench
  import pmic_pkg::*;
;
  logic clk = 0, sys_rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, sleep_exec = 0, serial1_done = 0;
  logic timer_clock_source_bit = 0, wakeup_req = 0, watch_tick = 0;
  logic [ADDR_W-1:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic [7:0] timer_a_count = 0, cpu_irq_req, rv, rn;
  logic [LINE_CNT-1:0] irq_line = 0;
  pmic_line_cfg_s line_cfg = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic subclock_en, noise_sample_en, a1, w1, b1;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
  logic [2:0] standby_wait_select;
  pmic_mode_e power_mode;
  int fail_count = 0, samples_checked = 0, cyc = 0, seed = 32'h50f74157;
  localparam logic [11:0] A_SC2 = {IDX_SYS_CTL2, 2'h0}, A_IEN = {IDX_IRQ_EN1, 2'h0};
  localparam logic [11:0] A_SC1 = {IDX_SYS_CTL1, 2'h0}, A_IRR = {IDX_IRQ_REQ1, 2'h0};

  pmic_top i_dut (.*);

  initial forever #20 clk = ~clk;
  // Hang guard well beyond the four hundred or so cycles the tests need
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      close_out;
    end
  end

  task close_out;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  // ----------------------------------------
  // AXI4-Lite master
  // ----------------------------------------
  task wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    // Handshakes are sampled before the edge; each channel is released at its own edge
    do
    begin
      @(negedge clk) {a1, w1, b1, br} = {s_axi_awready & s_axi_awvalid,
                                          s_axi_wready & s_axi_wvalid, s_axi_bvalid, s_axi_bresp};
      @(posedge clk);
      if (a1) s_axi_awvalid <= 0;
      if (w1) s_axi_wvalid <= 0;
    end while (!b1);
    s_axi_bready <= 0;
  endtask

  task rd(input logic [11:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(negedge clk) a1 = s_axi_arready;
    while (!a1);
    @(posedge clk);
    s_axi_arvalid <= 0;
    s_axi_rready <= 1;
    do @(negedge clk) {rv, rr} = {s_axi_rdata[7:0], s_axi_rresp};
    while (!s_axi_rvalid);
    @(posedge clk) s_axi_rready <= 0;
  endtask

  // A wake pulse passes the registered request gate, so the mode moves one edge later
  task sl(input pmic_mode_e m, input bit w = 1'b0);
    @(posedge clk) {wakeup_req, sleep_exec} <= {w, !w};
    @(posedge clk) {wakeup_req, sleep_exec} <= 2'b00;
    if (w)
      @(posedge clk);
    @(negedge clk) chk("power_mode", {29'h0, m}, {29'h0, power_mode});
  endtask

  function automatic logic [31:0] pulses(input logic [7:0] v, input bit sub);
    if (sub)
      return v[SC2_SA_LSB+1] ? 32'h20 : (v[SC2_SA_LSB] ? 32'h10 : 32'h8);
    return v[SC2_NOISE_SAMPLE_RATE_SELECT] ? 32'h10 : 32'h4;
  endfunction

  // Count divider pulses over 64 clocks of steady watch ticks
  task divs(input logic [7:0] v);
    logic [31:0] nn, sn;
    nn = 0;
    sn = 0;
    wr(A_SC2, v);
    @(posedge clk) watch_tick <= 1;
    repeat (64)
    begin
      @(negedge clk);
      nn = nn + noise_sample_en;
      sn = sn + subclock_en;
    end
    @(posedge clk) watch_tick <= 0;
    chk("noise_sample_en", pulses(v, 1'b0), nn);
    chk("subclock_en", pulses(v, 1'b1), sn);
  endtask

  initial
  begin
    repeat (2) @(posedge clk);
    sys_rst <= 0;
    rd(A_SC1); chk("sc1", SC1_RESET, rv);
    rd(A_SC2); chk("sc2", SC2_RESET, rv);
    rd(A_IRR); chk("irr", IRR_RESET, rv);
    rd(12'h3d0); chk("decerr", {RESP_DECERR, 8'h0}, {rr, rv});
    wr(12'h3d0, 8'h00);
    chk("bresp", RESP_DECERR, br);
    repeat (4)
    begin
      rn = 8'($random(seed));
      wr(A_IEN, rn); chk("bresp", RESP_OKAY, br); rd(A_IEN); chk("ien", rn, rv);
    end
    $display("test registers done");
    wr(A_IEN, 8'h80);
    @(posedge clk) timer_a_count <= 8'hff;
    @(posedge clk) timer_a_count <= 8'h00;
    repeat (3) @(negedge clk);
    chk("cpu_irq_req", 8'h80, cpu_irq_req);
    rd(A_IRR); chk("irr", 8'ha0, rv);
    @(posedge clk) serial1_done <= 1;
    @(posedge clk) serial1_done <= 0;
    rd(A_IRR); chk("irr", 8'he0, rv);
    chk("cpu_irq_req", 8'h80, cpu_irq_req);
    wr(A_IRR, 8'hff); rd(A_IRR); chk("irr", 8'he0, rv);
    wr(A_IRR, 8'h3f); rd(A_IRR); chk("irr", 8'h20, rv);
    @(posedge clk) line_cfg <= {5'h1f, 5'h15};
    @(posedge clk) irq_line <= 5'h1f;
    @(posedge clk) irq_line <= 5'h00;
    @(posedge clk);
    rd(A_IRR);
    chk("irr", 8'h3f, rv);
    wr(A_IRR, 8'h00);
    rd(A_IRR);
    chk("irr", 8'h20, rv);
    $display("test flags done");
    wr(A_IEN, 8'ha0);
    wr(A_SC2, 8'h0c); sl(PMIC_ACT_MED);
    wr(A_SC2, 8'h08); sl(PMIC_ACT_HIGH);
    wr(A_SC2, 8'h00); sl(PMIC_SLEEP);
    sl(PMIC_ACT_HIGH, 1'b1);
    @(posedge clk) timer_clock_source_bit <= 1;
    wr(A_SC1, 8'hb8);
    chk("standby_wait_select", 3'h3, standby_wait_select);
    wr(A_SC2, 8'h0c);
    sl(PMIC_SUBACTIVE);
    wr(A_SC1, 8'hb0);
    sl(PMIC_ACT_MED);
    wr(A_SC1, 8'hb8);
    sl(PMIC_SUBACTIVE);
    wr(A_SC1, 8'hb0);
    wr(A_SC2, 8'h08);
    sl(PMIC_ACT_HIGH);
    sl(PMIC_STANDBY);
    sl(PMIC_ACT_HIGH, 1'b1);
    wr(A_SC1, 8'hb8);
    sl(PMIC_SUBACTIVE);
    wr(A_SC2, 8'h00);
    sl(PMIC_WATCH);
    sl(PMIC_SUBACTIVE, 1'b1);
    wr(A_SC1, 8'h38);
    sl(PMIC_SUBSLEEP);
    sl(PMIC_SUBACTIVE, 1'b1);
    $display("test modes done");
    divs(8'h00);
    divs(8'h11);
    divs(8'h03);
    $display("test dividers done");
    close_out;
  end
endmodule
